//--- design/swc_pkg.sv
package swc_pkg;

   localparam logic [11:0] SWC_ADDR_STANDBY = 12'h000;
   localparam logic [11:0] SWC_ADDR_PROC = 12'h004;
   localparam logic [11:0] SWC_ADDR_STATUS = 12'h008;

   localparam int SWC_STBY_FLAG_BIT = 0;
   localparam int SWC_TB_LOW_BIT = 2;
   localparam int SWC_TB_HIGH_BIT = 3;
   localparam int SWC_ST_OSC_BIT = 4;
   localparam int SWC_ST_CPU_BIT = 5;
   localparam int SWC_ST_XMS_BIT = 6;
   localparam logic [7:0] SWC_PROC_RESET = 8'h4E;

   localparam int SWC_CLK_HZ = 40_000_000;
   localparam int SWC_STAB_MIN_MS = 30;
   localparam int SWC_STAB_MIN_CYC = (SWC_STAB_MIN_MS * SWC_CLK_HZ + 999) / 1000;
   localparam int SWC_TIME_BASE_W = 24;

   typedef enum logic [2:0] {
      SWC_RUN,
      SWC_HALT,
      SWC_XFER,
      SWC_STOP,
      SWC_STAB
   } swc_state_t;

   typedef struct packed {
      swc_state_t state;
      logic xfer_is_ms;
      logic [SWC_TIME_BASE_W-1:0] time_base_counter;
      logic [7:0] proc_ctrl;
      logic [2:0] nmi_sync;
      logic nmi_filt;
      logic cpu_clk_en;
      logic periph_clk_en;
      logic osc_en;
      logic xfer_grant;
      logic time_base_irq_suppress;
      logic vector_take;
      logic resume_next;
      logic [31:0] prdata;
      logic pslverr;
   } swc_regs_t;

   localparam swc_regs_t SWC_REGS_RESET = '{
      state: SWC_RUN,
      xfer_is_ms: 1'b0,
      time_base_counter: 24'h00_0000,
      proc_ctrl: SWC_PROC_RESET,
      nmi_sync: 3'h0,
      nmi_filt: 1'b0,
      cpu_clk_en: 1'b1,
      periph_clk_en: 1'b1,
      osc_en: 1'b1,
      xfer_grant: 1'b0,
      time_base_irq_suppress: 1'b0,
      vector_take: 1'b0,
      resume_next: 1'b0,
      prdata: 32'h0000_0000,
      pslverr: 1'b0
   };

   typedef struct packed {
      logic flag;
   } swc_flag_regs_t;

endpackage : swc_pkg

//--- design/swc_standby_wakeup_control.sv
`timescale 1ns/1ps
`default_nettype none

module swc_standby_flag
   import swc_pkg::*;
(
   input wire logic pclk,
   input wire logic por_n,
   input wire logic set_pulse,
   output logic flag
);
   swc_flag_regs_t f_reg;
   swc_flag_regs_t f_next;

   // presetn deliberately absent: the flag survives a pin reset
   always_comb begin
      f_next = f_reg;
      if (set_pulse) begin
         f_next.flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   assign flag = f_reg.flag;

   flag_sticky_a: assert property (@(posedge pclk) disable iff (!por_n)
      f_reg.flag |=> f_reg.flag)
      else $error("standby flag lost without power-up");

endmodule : swc_standby_flag

module swc_standby_wakeup_control
   import swc_pkg::*;
#(
   // half-interval cycle counts per interval select; defaults arbitrary
   parameter int unsigned STAB_CYC_0 = 32'h0008_0000,
   parameter int unsigned STAB_CYC_1 = 32'h0010_0000,
   parameter int unsigned STAB_CYC_2 = 32'h0020_0000,
   parameter int unsigned STAB_CYC_3 = 32'h0040_0000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_exec,
   input wire logic stop_exec,
   input wire logic nmi_pin,
   input wire logic irq_req,
   input wire logic irq_higher,
   input wire logic in_service,
   input wire logic ie_state,
   input wire logic ms_req,
   input wire logic dma_req,
   input wire logic xfer_done,
   input wire logic ms_count_zero,
   input wire logic ms_match,
   input wire logic dma_tc_zero,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_en,
   output logic xfer_grant,
   output logic time_base_irq_suppress,
   output logic vector_take,
   output logic resume_next,
   output logic standby_flag
);
   swc_regs_t r_reg;
   swc_regs_t r_next;

   logic nmi_edge;
   logic irq_ok;
   logic xfer_release;
   logic wr_access;
   logic flag_set;
   logic [1:0] tb_sel;
   logic [SWC_TIME_BASE_W-1:0] time_base_load;

   // only the second and third stages are looked at
   assign nmi_edge = r_reg.nmi_sync[1] & r_reg.nmi_sync[2] & ~r_reg.nmi_filt;
   assign irq_ok = irq_req & (~in_service | irq_higher);
   assign xfer_release = r_reg.xfer_is_ms ? (ms_count_zero | ms_match) : dma_tc_zero;
   assign wr_access = psel & penable & pwrite;
   assign flag_set = wr_access & (paddr == SWC_ADDR_STANDBY) & pwdata[SWC_STBY_FLAG_BIT];
   assign tb_sel = {r_reg.proc_ctrl[SWC_TB_HIGH_BIT], r_reg.proc_ctrl[SWC_TB_LOW_BIT]};

   always_comb begin
      case (tb_sel)
         2'h0: time_base_load = SWC_TIME_BASE_W'(STAB_CYC_0 - 1);
         2'h1: time_base_load = SWC_TIME_BASE_W'(STAB_CYC_1 - 1);
         2'h2: time_base_load = SWC_TIME_BASE_W'(STAB_CYC_2 - 1);
         default: time_base_load = SWC_TIME_BASE_W'(STAB_CYC_3 - 1);
      endcase
   end

   swc_standby_flag u_flag (
      .pclk(pclk),
      .por_n(por_n),
      .set_pulse(flag_set),
      .flag(standby_flag)
   );

   always_comb begin
      r_next = r_reg;
      r_next.vector_take = 1'b0;
      r_next.resume_next = 1'b0;
      r_next.nmi_sync = {r_reg.nmi_sync[1:0], nmi_pin};
      if (r_reg.nmi_sync[1] == r_reg.nmi_sync[2]) begin
         r_next.nmi_filt = r_reg.nmi_sync[2];
      end

      case (r_reg.state)
         SWC_RUN: begin
            if (stop_exec) begin
               r_next.state = SWC_STOP;
            end else if (halt_exec) begin
               r_next.state = SWC_HALT;
            end
         end
         SWC_HALT: begin
            if (nmi_edge) begin
               r_next.state = SWC_RUN;
               r_next.vector_take = 1'b1;
            end else if (irq_ok) begin
               r_next.state = SWC_RUN;
               r_next.vector_take = ie_state;
               r_next.resume_next = ~ie_state;
            end else if (ms_req | dma_req) begin
               r_next.state = SWC_XFER;
               r_next.xfer_is_ms = ms_req;
            end
         end
         SWC_XFER: begin
            if (xfer_done) begin
               if (xfer_release) begin
                  r_next.state = SWC_RUN;
                  r_next.vector_take = ie_state;
                  r_next.resume_next = ~ie_state;
               end else begin
                  r_next.state = SWC_HALT;
               end
            end
         end
         SWC_STOP: begin
            // maskable, dma and macro-service requests are not looked at
            if (nmi_edge) begin
               r_next.state = SWC_STAB;
               r_next.time_base_counter = time_base_load;
            end
         end
         SWC_STAB: begin
            if (r_reg.time_base_counter == '0) begin
               r_next.state = SWC_RUN;
               r_next.vector_take = 1'b1;
            end else begin
               r_next.time_base_counter = r_reg.time_base_counter - 1'b1;
            end
         end
         default: begin
            r_next.state = SWC_RUN;
         end
      endcase

      // gates follow the next state so they switch on the boundary edge
      r_next.cpu_clk_en = (r_next.state == SWC_RUN);
      r_next.periph_clk_en = (r_next.state == SWC_RUN) || (r_next.state == SWC_HALT) ||
         (r_next.state == SWC_XFER);
      r_next.osc_en = (r_next.state != SWC_STOP);
      r_next.xfer_grant = (r_next.state == SWC_XFER);
      r_next.time_base_irq_suppress = (r_next.state == SWC_STAB);

      if (wr_access && (paddr == SWC_ADDR_PROC)) begin
         r_next.proc_ctrl = pwdata[7:0];
      end
      if (psel && !penable) begin
         r_next.pslverr = 1'b0;
         case (paddr)
            SWC_ADDR_STANDBY: r_next.prdata = {31'h0000_0000, standby_flag};
            SWC_ADDR_PROC: r_next.prdata = {24'h00_0000, r_reg.proc_ctrl};
            SWC_ADDR_STATUS: begin
               r_next.prdata = 32'h0000_0000;
               r_next.prdata[2:0] = r_reg.state;
               r_next.prdata[SWC_ST_OSC_BIT] = r_reg.osc_en;
               r_next.prdata[SWC_ST_CPU_BIT] = r_reg.cpu_clk_en;
               r_next.prdata[SWC_ST_XMS_BIT] = r_reg.xfer_is_ms;
            end
            default: begin
               r_next.prdata = 32'h0000_0000;
               r_next.pslverr = 1'b1;
            end
         endcase
      end
   end

   // pin reset in any state restarts as a normal reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= SWC_REGS_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.prdata;
   assign pready = 1'b1;
   assign pslverr = r_reg.pslverr & psel & penable;
   assign cpu_clk_en = r_reg.cpu_clk_en;
   assign periph_clk_en = r_reg.periph_clk_en;
   assign osc_en = r_reg.osc_en;
   assign xfer_grant = r_reg.xfer_grant;
   assign time_base_irq_suppress = r_reg.time_base_irq_suppress;
   assign vector_take = r_reg.vector_take;
   assign resume_next = r_reg.resume_next;

   clk_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      r_reg.cpu_clk_en == (r_reg.state == SWC_RUN))
      else $error("cpu clock gate out of step with state");

   halt_periph_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_HALT) |-> (osc_en && periph_clk_en && !cpu_clk_en))
      else $error("halt stopped more than the cpu clock");

   halt_nmi_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_HALT && nmi_edge) |=> (vector_take && cpu_clk_en))
      else $error("nmi did not vector out of halt");

   halt_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_HALT && !nmi_edge && irq_ok && !ie_state)
      |=> (resume_next && !vector_take))
      else $error("disabled irq did not resume next instruction");

   halt_priority_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_HALT && !nmi_edge && in_service && !irq_higher && !ms_req &&
      !dma_req) |=> (r_reg.state == SWC_HALT))
      else $error("low priority request released halt");

   xfer_rehalt_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_XFER && xfer_done && !xfer_release)
      |=> (r_reg.state == SWC_HALT && !cpu_clk_en && !vector_take && !resume_next))
      else $error("unreleased transfer woke the cpu");

   xfer_release_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_XFER && xfer_done && xfer_release)
      |=> (cpu_clk_en && (vector_take == $past(ie_state)) && (resume_next != vector_take)))
      else $error("released transfer exit wrong");

   stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_STOP && !nmi_edge) |=> (r_reg.state == SWC_STOP && !osc_en))
      else $error("stop left without nmi");

   stop_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_STOP && nmi_edge)
      |=> (osc_en && r_reg.state == SWC_STAB &&
      r_reg.time_base_counter == $past(time_base_load)))
      else $error("nmi did not restart oscillator and counter");

   stab_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_STAB && r_reg.time_base_counter != '0)
      |=> (r_reg.state == SWC_STAB && !cpu_clk_en && time_base_irq_suppress))
      else $error("clock released before stabilisation count");

   stab_end_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_STAB && r_reg.time_base_counter == '0)
      |=> (cpu_clk_en && vector_take && !time_base_irq_suppress))
      else $error("stabilisation end not taken");

   halt_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_RUN && !stop_exec && halt_exec)
      |=> (r_reg.state == SWC_HALT && !cpu_clk_en && periph_clk_en))
      else $error("halt entry did not gate only the cpu clock");

   stop_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_RUN && stop_exec)
      |=> (r_reg.state == SWC_STOP && !osc_en && !periph_clk_en && !cpu_clk_en))
      else $error("stop entry left a clock running");

   halt_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_HALT && !nmi_edge && irq_ok && ie_state)
      |=> (vector_take && !resume_next && cpu_clk_en))
      else $error("enabled irq did not vector out of halt");

   xfer_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_HALT && !nmi_edge && !irq_ok && (ms_req || dma_req))
      |=> (xfer_grant && !cpu_clk_en && (r_reg.xfer_is_ms == $past(ms_req))))
      else $error("transfer not started from halt");

   stop_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
      (r_reg.state == SWC_STOP && !nmi_edge)
      |=> (!xfer_grant && !vector_take && !resume_next && !cpu_clk_en))
      else $error("stop answered a request other than nmi");

   stab_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
      time_base_irq_suppress
      |-> (osc_en && !cpu_clk_en && r_reg.state == SWC_STAB))
      else $error("suppress outside stabilisation");

   wake_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(vector_take && resume_next))
      else $error("vector and resume raised together");

   vector_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      vector_take |=> !vector_take)
      else $error("vector request held too long");

   resume_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      resume_next |=> !resume_next)
      else $error("resume request held too long");

   flag_set_a: assert property (@(posedge pclk) disable iff (!por_n)
      flag_set |=> standby_flag)
      else $error("standby flag write not taken");

endmodule : swc_standby_wakeup_control

`default_nettype wire

//--- tb/standby_wakeup_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module standby_wakeup_control_tb;
   import swc_pkg::*;
   // short counts for simulation; real software picks a half interval of 30 ms or more
   localparam int STAB_TAB [4] = '{4, 6, 9, 16};
   logic pclk = 1'b0;
   logic presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0001_30FA;
   logic halt_exec = 1'b0, stop_exec = 1'b0, nmi_pin = 1'b0, irq_req = 1'b0;
   logic irq_higher = 1'b0, in_service = 1'b0, ie_state = 1'b0, ms_req = 1'b0;
   logic dma_req = 1'b0, fin = 1'b0, hit = 1'b0;
   logic [2:0] lat = 3'h0;
   logic pready, pslverr, xfer_done, ms_count_zero, ms_match, dma_tc_zero, woke;
   logic cpu_clk_en, periph_clk_en, osc_en, xfer_grant, time_base_irq_suppress;
   logic vector_take, resume_next, standby_flag;
   logic exp_q [$];
   int num_errors = 0, check_count = 0;

   always #12.5 pclk = ~pclk;
   always_comb woke = vector_take | resume_next;

   swc_standby_wakeup_control #(.STAB_CYC_0(STAB_TAB[0]), .STAB_CYC_1(STAB_TAB[1]),
      .STAB_CYC_2(STAB_TAB[2]), .STAB_CYC_3(STAB_TAB[3])) dut (.pclk, .presetn, .por_n,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .halt_exec,
      .stop_exec, .nmi_pin, .irq_req, .irq_higher, .in_service, .ie_state, .ms_req,
      .dma_req, .xfer_done, .ms_count_zero, .ms_match, .dma_tc_zero, .cpu_clk_en,
      .periph_clk_en, .osc_en, .xfer_grant, .time_base_irq_suppress, .vector_take,
      .resume_next, .standby_flag);

   swc_xfer_model far_end (.pclk, .presetn, .xfer_grant, .lat, .fin, .hit, .xfer_done,
      .ms_count_zero, .ms_match, .dma_tc_zero);

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic cmp_out(input logic v);
      check_count++;
      if ({vector_take, resume_next} !== {v, ~v}) begin
         num_errors++;
         $display("wrong value at %0t: wake kind", $time);
      end
   endtask : cmp_out

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   // at least one edge, then bounded; running out ends the run
   task automatic wait_hi(ref logic s, input int lim);
      int i;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (s !== 1'b1 && i < lim);
      if (s !== 1'b1) begin
         num_errors++;
         $display("wrong value at %0t: timeout", $time);
         summarize();
      end
   endtask : wait_hi

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wait_hi(pready, 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-drives psel in the same step
      @(posedge pclk);
   endtask : apb

   task automatic halt_in(input logic ie);
      ie_state <= ie;
      halt_exec <= 1'b1;
      @(posedge pclk);
      halt_exec <= 1'b0;
      tick(2);
      chk({cpu_clk_en, periph_clk_en, osc_en}, 3'b011, "halt clocks");
   endtask : halt_in

   // src: 0 irq, 1 nmi, 2 macro-service, 3 dma
   task automatic hcase(input logic ie, input int src, input logic f, input logic h,
      input logic rel);
      seed = lfsr(seed);
      lat <= seed[2:0];
      fin <= f;
      hit <= h;
      halt_in(ie);
      exp_q.push_back(src == 1 || ie);
      case (src)
         0: irq_req <= 1'b1;
         1: nmi_pin <= 1'b1;
         2: ms_req <= 1'b1;
         default: dma_req <= 1'b1;
      endcase
      if (src > 1) begin
         wait_hi(xfer_grant, 16);
         ms_req <= 1'b0;
         dma_req <= 1'b0;
         if (!rel) begin
            tick(12);
            chk({cpu_clk_en, xfer_grant}, 0, "rehalt");
            irq_req <= 1'b1;
         end
      end
      wait_hi(woke, 64);
      irq_req <= 1'b0;
      nmi_pin <= 1'b0;
      tick(3);
      chk(cpu_clk_en, 1, "run again");
   endtask : hcase

   always @(posedge pclk) begin
      if (woke === 1'b1) begin
         if (exp_q.size() == 0) chk(0, 1, "unexpected wake");
         else cmp_out(exp_q.pop_front());
      end
   end

   initial begin
      logic [31:0] rd;
      logic err;
      int n;
      tick(2);
      por_n <= 1'b1;
      tick(3);
      presetn <= 1'b1;
      tick(1);
      chk(standby_flag, 0, "flag at power-up");
      apb(1'b0, SWC_ADDR_PROC, 32'h0000_0000, rd, err);
      chk(rd, 32'h0000_004E, "proc reset");
      apb(1'b1, SWC_ADDR_STANDBY, 32'h0000_0001, rd, err);
      apb(1'b0, SWC_ADDR_STANDBY, 32'h0000_0000, rd, err);
      chk({rd[0], standby_flag}, 2'b11, "flag set");
      apb(1'b0, 12'h00C, 32'h0000_0000, rd, err);
      chk(err, 1, "unmapped");
      apb(1'b0, SWC_ADDR_STATUS, 32'h0000_0000, rd, err);
      chk(rd, (32'h0000_0001 << SWC_ST_OSC_BIT) | (32'h0000_0001 << SWC_ST_CPU_BIT),
         "status run");
      $display("registers done");
      hcase(1'b1, 0, 1'b0, 1'b0, 1'b1);
      hcase(1'b0, 0, 1'b0, 1'b0, 1'b1);
      hcase(1'b0, 1, 1'b0, 1'b0, 1'b1);
      hcase(1'b1, 2, 1'b1, 1'b0, 1'b1);
      hcase(1'b0, 2, 1'b0, 1'b1, 1'b1);
      hcase(1'b1, 2, 1'b0, 1'b0, 1'b0);
      hcase(1'b1, 3, 1'b1, 1'b0, 1'b1);
      hcase(1'b0, 3, 1'b1, 1'b0, 1'b1);
      hcase(1'b0, 3, 1'b0, 1'b0, 1'b0);
      in_service <= 1'b1;
      halt_in(1'b1);
      irq_req <= 1'b1;
      tick(8);
      chk(cpu_clk_en, 0, "low priority");
      exp_q.push_back(1'b1);
      irq_higher <= 1'b1;
      wait_hi(woke, 16);
      irq_req <= 1'b0;
      irq_higher <= 1'b0;
      in_service <= 1'b0;
      halt_in(1'b0);
      presetn <= 1'b0;
      tick(2);
      chk({cpu_clk_en, standby_flag}, 2'b11, "halt reset");
      presetn <= 1'b1;
      $display("halt done");
      seed = lfsr(seed);
      apb(1'b1, SWC_ADDR_PROC, {24'h00_0000, seed[7:0]}, rd, err);
      apb(1'b0, SWC_ADDR_PROC, 32'h0000_0000, rd, err);
      chk(rd, {24'h00_0000, seed[7:0]}, "proc write");
      stop_exec <= 1'b1;
      @(posedge pclk);
      stop_exec <= 1'b0;
      irq_req <= 1'b1;
      ms_req <= 1'b1;
      dma_req <= 1'b1;
      tick(8);
      chk({osc_en, periph_clk_en, cpu_clk_en, xfer_grant}, 0, "stopped");
      irq_req <= 1'b0;
      ms_req <= 1'b0;
      dma_req <= 1'b0;
      exp_q.push_back(1'b1);
      nmi_pin <= 1'b1;
      wait_hi(time_base_irq_suppress, 16);
      chk({osc_en, cpu_clk_en}, 2'b10, "restart");
      for (n = 0; n < 64 && time_base_irq_suppress === 1'b1; n++) @(posedge pclk);
      chk(n, STAB_TAB[seed[3:2]], "stab length");
      nmi_pin <= 1'b0;
      tick(3);
      chk(cpu_clk_en, 1, "stop wake");
      stop_exec <= 1'b1;
      @(posedge pclk);
      stop_exec <= 1'b0;
      tick(3);
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      apb(1'b0, SWC_ADDR_PROC, 32'h0000_0000, rd, err);
      chk({osc_en, cpu_clk_en, standby_flag, rd[7:0]}, {3'b111, 8'h4E}, "stop reset");
      $display("stop done");
      summarize();
   end
endmodule : standby_wakeup_control_tb

`default_nettype wire

//--- tb/swc_xfer_model.sv
`timescale 1ns/1ps
`default_nettype none

module swc_xfer_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic xfer_grant,
   input wire logic [2:0] lat,
   input wire logic fin,
   input wire logic hit,
   output logic xfer_done,
   output logic ms_count_zero,
   output logic ms_match,
   output logic dma_tc_zero
);
   logic [2:0] cnt_reg;
   // flags mean nothing outside done; inverted there so a stale sample shows up
   assign ms_count_zero = xfer_done ? fin : ~fin;
   assign ms_match = xfer_done ? hit : ~hit;
   assign dma_tc_zero = xfer_done ? fin : ~fin;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 3'h0;
         xfer_done <= 1'b0;
      end else begin
         cnt_reg <= 3'h0;
         xfer_done <= 1'b0;
         // done only inside a grant, after a variable latency
         if (xfer_grant && !xfer_done) begin
            cnt_reg <= cnt_reg + 3'h1;
            xfer_done <= (cnt_reg == lat);
         end
      end
   end
endmodule : swc_xfer_model

`default_nettype wire
